// ==== uhs_pkg.sv ====
`default_nettype none

package uhs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] LIST_FILLED_FLAGS_OFF  = 16'h0334;
  localparam logic [15:0] ASYNC_DONE_TIMEOUT_OFF = 16'h0338;
  localparam logic [15:0] PIO_READ_POINTER_OFF   = 16'h033c;
  localparam logic [15:0] EDGE_IRQ_PACING_OFF    = 16'h0340;

  localparam logic [31:0] LIST_FILLED_FLAGS_RST  = 32'h0000_0000;
  localparam logic [31:0] ASYNC_DONE_TIMEOUT_RST = 32'h0000_0000;
  localparam logic [31:0] PIO_READ_POINTER_RST   = 32'h0000_0000;
  localparam logic [7:0]  MIN_WIDTH_RST          = 8'h00;
  localparam logic [15:0] BANK_PTR_RST           = 16'h0000;
  localparam logic [1:0]  BANK_SEL_RST           = 2'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ASYNC_LIST_FILLED_BIT = 0;
  localparam int INT_LIST_FILLED_BIT   = 1;
  localparam int ISO_LIST_FILLED_BIT   = 2;
  localparam int LIST_COUNT            = 3;
  localparam int START_ADDR_LSB        = 0;
  localparam int START_ADDR_MSB        = 15;
  localparam int BANK_SEL_LSB          = 16;
  localparam int BANK_SEL_MSB          = 17;
  localparam int MIN_WIDTH_LSB         = 24;
  localparam int MIN_WIDTH_MSB         = 31;
  localparam int BANK_COUNT            = 4;

  // Each programmed-I/O read moves the pointer on by one word address.
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 25_000_000;
  localparam int MS_TIME_US     = 1000;
  localparam int UFRAME_TIME_US = 125;
  localparam int MS_CYCLES      = (CLK_HZ / 1_000_000) * MS_TIME_US;
  localparam int UFRAME_CYCLES  = (CLK_HZ / 1_000_000) * UFRAME_TIME_US;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } uhsBusReq_t;

endpackage

`default_nettype wire

// ==== uhs_ms_timer.sv ====
`timescale 1ns/1ns
`default_nettype none

module uhs_ms_timer
  import uhs_pkg::*;
#(
  parameter int MsCycles = MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstSync_b,
  // Control
  input  wire logic        start,
  input  wire logic        clear,
  input  wire logic [31:0] limit,
  // Status
  output logic             expired
);

  logic [31:0] divCnt_r;
  logic [31:0] msCnt_r;
  logic        running_r;
  logic        expired_r;
  logic        msTick;
  logic        lastMs;

  assign msTick  = running_r && (divCnt_r == 32'(MsCycles - 1));
  assign lastMs  = msTick && (msCnt_r == limit - 32'h1);
  assign expired = expired_r;

  // The divider rests while idle, so the first millisecond is a full one.
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      divCnt_r <= 32'h0;
    end else if (!running_r || msTick) begin
      divCnt_r <= 32'h0;
    end else begin
      divCnt_r <= divCnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      msCnt_r <= 32'h0;
    end else if (!running_r) begin
      msCnt_r <= 32'h0;
    end else if (msTick) begin
      msCnt_r <= msCnt_r + 32'h1;
    end
  end

  // A zero limit disables the timeout altogether.
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      running_r <= 1'b0;
    end else if (lastMs) begin
      running_r <= 1'b0;
    end else if (start && !running_r && (limit != 32'h0)) begin
      running_r <= 1'b1;
    end else if (clear) begin
      running_r <= 1'b0;
    end
  end

  // Expiry wins over an acknowledge in the same cycle.
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      expired_r <= 1'b0;
    end else if (lastMs) begin
      expired_r <= 1'b1;
    end else if (clear) begin
      expired_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== uhs_edge_pacer.sv ====
`timescale 1ns/1ns
`default_nettype none

module uhs_edge_pacer
  import uhs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstSync_b,
  // Control
  input  wire logic [7:0] minWidth,
  // Events
  input  wire logic       eventIn,
  output logic            edgeIrq
);

  logic [11:0] uframeCnt_r;
  logic [7:0]  gapCnt_r;
  logic        pending_r;
  logic        edgeIrq_r;
  logic        uframeTick;
  logic        fire;

  assign uframeTick = (uframeCnt_r == 12'(UFRAME_CYCLES - 1));
  // A zero width fires at once, even while a gap left over from an earlier
  // nonzero setting is still counting down.
  assign fire       = ((gapCnt_r == 8'h00) || (minWidth == 8'h00)) && (eventIn || pending_r);
  assign edgeIrq    = edgeIrq_r;

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      uframeCnt_r <= 12'h000;
    end else if (uframeTick) begin
      uframeCnt_r <= 12'h000;
    end else begin
      uframeCnt_r <= uframeCnt_r + 12'h001;
    end
  end

  // The gap is counted in whole microframe ticks, so the real spacing may be
  // up to one microframe shorter than asked, or one clock longer when a fire lands on a tick.
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      gapCnt_r <= 8'h00;
    end else if (minWidth == 8'h00) begin
      gapCnt_r <= 8'h00;
    end else if (fire) begin
      gapCnt_r <= minWidth;
    end else if (uframeTick && (gapCnt_r != 8'h00)) begin
      gapCnt_r <= gapCnt_r - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pending_r <= 1'b0;
    end else if (fire) begin
      pending_r <= 1'b0;
    end else if (eventIn) begin
      pending_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      edgeIrq_r <= 1'b0;
    end else begin
      edgeIrq_r <= fire;
    end
  end

endmodule

`default_nettype wire

// ==== uhs_sched_regs.sv ====
`timescale 1ns/1ns
`default_nettype none

// What this block does
// RULE1 - Iso filled bit enables iso list
// RULE2 - Interrupt filled bit enables interrupt list
// RULE3 - Async filled bit enables async list
// RULE4 - Walk only valid, unskipped descriptor headers
// RULE5 - Software writes reserved bits as reset
// RULE6 - Millisecond async-done timeout raises enabled interrupt
// RULE7 - Timeout for async completions; resets zero
// RULE8 - Software sets start address before reading
// RULE9 - Memory write latches pointer per bank
// RULE10 - Each bank read advances that pointer
// RULE11 - Bits 17:16 select one of four banks
// RULE12 - Bits 15:0 give read start address
// RULE13 - Start address serves programmed reads only
// RULE14 - Minimum edge-interrupt spacing in microframes
module uhs_sched_regs
  import uhs_pkg::*;
#(
  parameter int MsCycles = MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register access from the processor interface
  input  wire uhsBusReq_t  cpuReq,
  output logic [31:0]      rdData,
  output logic             rdValid,
  // Descriptor scheduler
  output logic [2:0]       listEnable,
  input  wire logic        hdrValid,
  input  wire logic        hdrSkip,
  input  wire logic [1:0]  hdrList,
  output logic             hdrTake,
  // Async-done timeout
  input  wire logic        asyncDone,
  input  wire logic        asyncDoneAck,
  input  wire logic        irqEnable,
  output logic             asyncTimeoutIrq,
  // Programmed-I/O memory reads
  input  wire logic        pioRead,
  input  wire logic [1:0]  pioBank,
  output logic [15:0]      pioAddr,
  // Edge interrupt pacing
  input  wire logic        edgeEvent,
  output logic             edgeIrq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_b <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  logic wrFlags;
  logic wrTimeout;
  logic wrMem;
  logic wrPacing;

  assign wrFlags   = cpuReq.wr && hit(cpuReq.addr, LIST_FILLED_FLAGS_OFF);
  assign wrTimeout = cpuReq.wr && hit(cpuReq.addr, ASYNC_DONE_TIMEOUT_OFF);
  assign wrMem     = cpuReq.wr && hit(cpuReq.addr, PIO_READ_POINTER_OFF);
  assign wrPacing  = cpuReq.wr && hit(cpuReq.addr, EDGE_IRQ_PACING_OFF);

  // ----------------------------------------------------------------
  // List filled flags
  // ----------------------------------------------------------------
  logic [2:0] listFilled_r;

  // Reserved bits are not stored; they read back as zero.
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      listFilled_r <= LIST_FILLED_FLAGS_RST[2:0];
    end else if (wrFlags) begin
      listFilled_r <= cpuReq.wdata[2:0]; // see RULE1 see RULE2 see RULE3
    end
  end

  assign listEnable = listFilled_r;

  // A header is handed to the scheduler only when its list is enabled.
  always_comb begin
    hdrTake = 1'b0;
    if (hdrList != 2'h3) begin
      hdrTake = listFilled_r[hdrList] && hdrValid && !hdrSkip; // see RULE4
    end
  end

  // ----------------------------------------------------------------
  // Async-done timeout
  // ----------------------------------------------------------------
  logic [31:0] timeout_r;
  logic        expired;
  logic        timeoutIrq_r;

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      timeout_r <= ASYNC_DONE_TIMEOUT_RST; // see RULE7
    end else if (wrTimeout) begin
      timeout_r <= cpuReq.wdata;
    end
  end

  // Async completions start the timer only while the async list is enabled.
  uhs_ms_timer #(
    .MsCycles (MsCycles)
  ) msTimer (
    .clk       (clk),
    .rstSync_b (rstSync_b),
    .start     (asyncDone && listFilled_r[ASYNC_LIST_FILLED_BIT]), // see RULE7
    .clear     (asyncDoneAck),
    .limit     (timeout_r),
    .expired   (expired)
  );

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      timeoutIrq_r <= 1'b0;
    end else begin
      timeoutIrq_r <= expired && irqEnable; // see RULE6
    end
  end

  assign asyncTimeoutIrq = timeoutIrq_r;

  // ----------------------------------------------------------------
  // Programmed-I/O read pointers
  // ----------------------------------------------------------------
  logic [15:0] bankPtr_r [BANK_COUNT];
  logic [1:0]  bankSel_r;
  logic [1:0]  wrBank;

  assign wrBank = cpuReq.wdata[BANK_SEL_MSB:BANK_SEL_LSB];

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      bankSel_r <= BANK_SEL_RST;
    end else if (wrMem) begin
      bankSel_r <= wrBank; // see RULE11
    end
  end

  // A new start address beats a read of the same bank in the same cycle,
  // because software rewrites the pointer exactly to restart the run.
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      for (int i = 0; i < BANK_COUNT; i++) begin
        bankPtr_r[i] <= BANK_PTR_RST;
      end
    end else begin
      for (int i = 0; i < BANK_COUNT; i++) begin
        if (wrMem && (wrBank == 2'(i))) begin
          bankPtr_r[i] <= cpuReq.wdata[START_ADDR_MSB:START_ADDR_LSB]; // see RULE9 see RULE12
        end else if (pioRead && (pioBank == 2'(i))) begin
          bankPtr_r[i] <= bankPtr_r[i] + PTR_STEP; // see RULE10
        end
      end
    end
  end

  // DMA has its own address register; this pointer feeds PIO reads alone.
  assign pioAddr = bankPtr_r[pioBank]; // see RULE13

  // ----------------------------------------------------------------
  // Edge interrupt pacing
  // ----------------------------------------------------------------
  logic [7:0] minWidth_r;

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      minWidth_r <= MIN_WIDTH_RST;
    end else if (wrPacing) begin
      minWidth_r <= cpuReq.wdata[MIN_WIDTH_MSB:MIN_WIDTH_LSB];
    end
  end

  uhs_edge_pacer pacer (
    .clk       (clk),
    .rstSync_b (rstSync_b),
    .minWidth  (minWidth_r), // see RULE14
    .eventIn   (edgeEvent),
    .edgeIrq   (edgeIrq)
  );

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  logic [31:0] rdData_r;
  logic        rdValid_r;

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rdData_r <= 32'h0000_0000;
    end else if (cpuReq.rd) begin
      unique case (cpuReq.addr)
        LIST_FILLED_FLAGS_OFF:  rdData_r <= {29'h0, listFilled_r};
        ASYNC_DONE_TIMEOUT_OFF: rdData_r <= timeout_r;
        PIO_READ_POINTER_OFF:   rdData_r <= {14'h0, bankSel_r, bankPtr_r[bankSel_r]};
        EDGE_IRQ_PACING_OFF:    rdData_r <= {minWidth_r, 24'h00_0000};
        default:                rdData_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= cpuReq.rd;
    end
  end

  assign rdData  = rdData_r;
  assign rdValid = rdValid_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSync_b);

  sequence flagsWrite;
    wrFlags;
  endsequence

  sequence memWriteThenRead;
    wrMem ##1 cpuReq.rd && hit(cpuReq.addr, PIO_READ_POINTER_OFF) && !cpuReq.wr
      && !(pioRead && pioBank == bankSel_r);
  endsequence

  list_enable_follows_a: assert property ( // see RULE1 see RULE2 see RULE3
    flagsWrite |=> listEnable == $past(cpuReq.wdata[2:0]))
    else $error("list enables do not follow the flags write");

  header_gate_a: assert property ( // see RULE4
    hdrTake |-> hdrValid && !hdrSkip && hdrList != 2'h3 && listEnable[hdrList])
    else $error("header taken from a disabled list or invalid header");

  timeout_irq_gate_a: assert property ( // see RULE6
    $rose(asyncTimeoutIrq) |-> $past(irqEnable) && $past(expired))
    else $error("timeout interrupt without enable or expiry");

  timeout_write_a: assert property ( // see RULE7
    wrTimeout ##1 (cpuReq.rd && !cpuReq.wr && hit(cpuReq.addr, ASYNC_DONE_TIMEOUT_OFF))
      |=> rdValid && rdData == $past(cpuReq.wdata, 2))
    else $error("timeout register read back differs from write");

  pointer_latch_a: assert property ( // see RULE9
    wrMem |=> bankPtr_r[$past(wrBank)] == $past(cpuReq.wdata[15:0]))
    else $error("bank pointer not latched on write");

  pointer_advance_a: assert property ( // see RULE10
    pioRead && !wrMem |=> bankPtr_r[$past(pioBank)] == $past(pioAddr) + PTR_STEP)
    else $error("bank pointer did not advance on read");

  bank_readback_a: assert property ( // see RULE11 see RULE12
    memWriteThenRead |=> rdData[17:16] == $past(cpuReq.wdata[17:16], 2)
      && rdData[15:0] == $past(cpuReq.wdata[15:0], 2) && rdData[31:18] == 14'h0)
    else $error("memory register read back differs from write");

  edge_zero_width_a: assert property ( // see RULE14
    edgeEvent && minWidth_r == 8'h00 && !wrPacing |=> edgeIrq)
    else $error("edge interrupt delayed with zero minimum width");

  edge_spacing_a: assert property ( // see RULE14
    edgeIrq && minWidth_r != 8'h00 && !wrPacing |=> !edgeIrq [*8])
    else $error("edge interrupts closer than the minimum width");

endmodule

`default_nettype wire

// ==== uhs_cpu_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module uhs_cpu_model
  import uhs_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register bus
  output var uhsBusReq_t   req,
  input  wire logic [31:0] rdData,
  input  wire logic        rdValid
);
  initial req = '0;

  // A released bus clears wr and rd and shows the inverse of its last address and data, so a stale copy never matches.
  task automatic release_bus();
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~req.addr;
    req.wdata = ~req.wdata;
  endtask

  // Callers always pass zeros in reserved bit positions.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    release_bus();
  endtask

  // Write, then read the same address with no idle cycle in between.
  task automatic wr_rd(input logic [15:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic ok);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    req.rd = 1'b1;
    @(negedge clk);
    release_bus();
    ok = (rdValid === 1'b1);
    q = rdData;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d = '0;
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    release_bus();
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rdValid === 1'b1) begin
        ok = 1'b1;
        d = rdData;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule

`default_nettype wire

// ==== tb_uhs_sched_regs.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_uhs_sched_regs;
  import uhs_pkg::*;
  localparam int MS = 4;
  logic        clk, rst_b, hdrValid, hdrSkip, asyncDone, asyncDoneAck, irqEnable;
  logic        pioRead, edgeEvent, rdValid, hdrTake, asyncTimeoutIrq, edgeIrq;
  logic [1:0]  hdrList, pioBank;
  logic [2:0]  listEnable;
  logic [15:0] pioAddr;
  logic [31:0] rdData;
  uhsBusReq_t  cpuReq;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          c;

  uhs_sched_regs #(.MsCycles(MS)) u_dut (
    .clk(clk), .rst_b(rst_b), .cpuReq(cpuReq), .rdData(rdData), .rdValid(rdValid),
    .listEnable(listEnable), .hdrValid(hdrValid), .hdrSkip(hdrSkip), .hdrList(hdrList),
    .hdrTake(hdrTake), .asyncDone(asyncDone), .asyncDoneAck(asyncDoneAck),
    .irqEnable(irqEnable), .asyncTimeoutIrq(asyncTimeoutIrq), .pioRead(pioRead),
    .pioBank(pioBank), .pioAddr(pioAddr), .edgeEvent(edgeEvent), .edgeIrq(edgeIrq));

  uhs_cpu_model u_cpu (.clk(clk), .req(cpuReq), .rdData(rdData), .rdValid(rdValid));

  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        ok;
    u_cpu.rd(a, d, ok);
    chk("rdValid", 32'h1, {31'h0, ok});
    chk(nm, e, d);
  endtask

  // Back-to-back write and read of one register.
  task automatic wrchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        ok;
    u_cpu.wr_rd(a, e, d, ok);
    chk("rdValid", 32'h1, {31'h0, ok});
    chk(nm, e, d);
  endtask

  task automatic pio_rd(input int b, input int n);
    repeat (n) begin
      @(negedge clk);
      pioBank = 2'(b);
      pioRead = 1'b1;
      @(negedge clk);
      pioRead = 1'b0;
    end
  endtask

  task automatic ptr_chk(input int b, input logic [15:0] e);
    @(negedge clk);
    pioBank = 2'(b);
    #1;
    chk("pioAddr", {16'h0, e}, {16'h0, pioAddr});
  endtask

  // The wait is bounded so a timer that never expires still ends the call.
  task automatic done_run(input int lim, output int cnt);
    @(negedge clk);
    asyncDone = 1'b1;
    @(negedge clk);
    asyncDone = 1'b0;
    cnt = 1;
    while (asyncTimeoutIrq !== 1'b1 && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
  endtask

  task automatic ack();
    @(negedge clk);
    asyncDoneAck = 1'b1;
    @(negedge clk);
    asyncDoneAck = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    #(60000 * 40);
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    rst_b = 0;
    {hdrValid, hdrSkip, asyncDone, asyncDoneAck, irqEnable, pioRead, edgeEvent} = '0;
    hdrList = 2'h0;
    pioBank = 2'h0;
    repeat (16) @(negedge clk);
    rst_b = 1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 5; i++) rchk("resetVal", 16'h0334 + 16'(4 * i), 32'h0);
    for (int f = 0; f < 8; f++) begin
      u_cpu.wr(LIST_FILLED_FLAGS_OFF, 32'(f));
      rchk("flags", LIST_FILLED_FLAGS_OFF, 32'(f));
      chk("listEnable", 32'(f), {29'h0, listEnable});
      for (int k = 0; k < 16; k++) begin
        @(negedge clk);
        hdrList = 2'(k);
        hdrValid = k[2];
        hdrSkip = k[3];
        #1;
        c = int'((k % 4 != 3) && f[k % 4] && k[2] && !k[3]);
        chk("hdrTake", 32'(c), {31'h0, hdrTake});
      end
    end
    hdrValid = 1'b0;
    for (int b = 0; b < 3; b++) begin
      u_cpu.wr(PIO_READ_POINTER_OFF, {14'h0, 2'(b), 16'h1000 + 16'(b)});
    end
    wrchk("memReg", PIO_READ_POINTER_OFF, 32'h0003_1003);
    rchk("memReg", PIO_READ_POINTER_OFF, 32'h0003_1003);
    for (int b = 0; b < 4; b++) pio_rd(b, b + 1);
    for (int b = 0; b < 4; b++) ptr_chk(b, 16'h1000 + 16'(2 * b + 1));
    u_cpu.wr(PIO_READ_POINTER_OFF, 32'h0002_ffff);
    ptr_chk(2, 16'hffff);
    pio_rd(2, 1);
    ptr_chk(2, 16'h0000);
    ptr_chk(1, 16'h1003);
    wrchk("timeout", ASYNC_DONE_TIMEOUT_OFF, 32'ha5a5_5a5a);
    rchk("timeout", ASYNC_DONE_TIMEOUT_OFF, 32'ha5a5_5a5a);
    u_cpu.wr(LIST_FILLED_FLAGS_OFF, 32'h1);
    u_cpu.wr(ASYNC_DONE_TIMEOUT_OFF, 32'h2);
    irqEnable = 1'b1;
    done_run(100, c);
    chk("irqDelay", 32'(2 * MS + 2), 32'(c));
    ack();
    chk("irqAfterAck", 32'h0, {31'h0, asyncTimeoutIrq});
    irqEnable = 1'b0;
    done_run(40, c);
    chk("irqMasked", 32'h0, {31'h0, asyncTimeoutIrq});
    irqEnable = 1'b1;
    repeat (2) @(negedge clk);
    chk("irqUnmasked", 32'h1, {31'h0, asyncTimeoutIrq});
    ack();
    u_cpu.wr(LIST_FILLED_FLAGS_OFF, 32'h6);
    done_run(40, c);
    chk("irqListOff", 32'h0, {31'h0, asyncTimeoutIrq});
    u_cpu.wr(LIST_FILLED_FLAGS_OFF, 32'h1);
    u_cpu.wr(ASYNC_DONE_TIMEOUT_OFF, 32'h0);
    done_run(40, c);
    chk("irqZero", 32'h0, {31'h0, asyncTimeoutIrq});
    @(negedge clk);
    edgeEvent = 1'b1;
    @(negedge clk);
    edgeEvent = 1'b0;
    chk("edgeIrq", 32'h1, {31'h0, edgeIrq});
    u_cpu.wr(EDGE_IRQ_PACING_OFF, 32'h0200_0000);
    rchk("pacing", EDGE_IRQ_PACING_OFF, 32'h0200_0000);
    c = 0;
    for (int i = 0; i < 6500; i++) begin
      @(negedge clk);
      c += int'(edgeIrq === 1'b1);
      edgeEvent = (i % 10 == 0) && (i < 30);
    end
    chk("edgePulses", 32'h2, 32'(c));
    test_done();
  end
endmodule

`default_nettype wire
